/* File: design/prdr_top.v */
// Resource decoder: memory map, I/O steering, config ports, IRQ routing.
// Assumes the host presents one cycle per valid strobe on mclk_in.
`timescale 1ns/100ps
`default_nettype none
`include "prdr_regs.vh"

module prdr_top
(
    input wire mclk_in,
    input wire rst_n_in,
    // Host cycle.
    input wire cyc_valid_in,
    input wire cyc_io_in,
    input wire cyc_write_in,
    input wire [31:0] cyc_addr_in,
    input wire [31:0] cyc_wdata_in,
    input wire [31:0] top_of_dram_in,
    input wire [31:0] high_window_in,
    input wire [31:0] cfg_rdata_in,
    output reg mem_region_valid_out,
    output reg [2:0] mem_region_out,
    output reg io_valid_out,
    output reg [2:0] io_target_out,
    output reg [31:0] rdata_out,
    output reg [31:0] config_address_out,
    output reg cfg_data_strobe_out,
    output reg cfg_data_write_out,
    output reg [31:0] cfg_wdata_out,
    output reg io_in_alloc_area_out,
    // Interrupts.
    input wire apic_mode_in,
    input wire [3:0] pci_int_in,
    input wire [7:0] route_line_in,
    input wire [15:0] serial_irq_in,
    input wire [6:0] fixed_src_in,
    input wire [5:0] root_port_in,
    input wire [7:0] dev_irq_in,
    input wire [15:0] steer_in,
    output wire [23:0] irq_out
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    // Inclusive range check, used for every I/O window except on-board range 0, the two config ports and the downward-allocated window.
    function in_range;
        input [15:0] a;
        input [15:0] lo;
        input [15:0] hi;
        begin
            in_range = (a >= lo) && (a <= hi);
        end
    endfunction

    reg [2:0] next_region;
    reg [2:0] next_target;
    reg [31:0] next_rdata;
    wire [15:0] io_addr;
    wire [15:0] io_word;

    assign io_addr = cyc_addr_in[15:0];
    assign io_word = {io_addr[15:2], 2'b00};

    // ------------------------------------------------------------
    // Memory decode
    // ------------------------------------------------------------

    // Regions are tested top down so each boundary below the high region is one compare.
    always @*
    begin
        // high region at or above the high window or the top of DRAM
        if (cyc_addr_in >= high_window_in || cyc_addr_in >= top_of_dram_in)
            next_region = `PRDR_MREG_HIGH;
        else if (cyc_addr_in >= `PRDR_MEM_EXT_LO)
            next_region = `PRDR_MREG_EXT;
        else if (cyc_addr_in >= `PRDR_MEM_RTBIOS_LO)
            next_region = `PRDR_MREG_RTBIOS;
        else if (cyc_addr_in >= `PRDR_MEM_EXP_LO)
            next_region = `PRDR_MREG_EXP;
        else if (cyc_addr_in >= `PRDR_MEM_VIDEO_LO)
            next_region = `PRDR_MREG_VIDEO;
        else if (cyc_addr_in >= `PRDR_MEM_EBDA_LO)
            next_region = `PRDR_MREG_EBDA;
        else
            next_region = `PRDR_MREG_CONV;
    end

    // ------------------------------------------------------------
    // I/O decode
    // ------------------------------------------------------------

    // Positive decoders first; the PCI bus takes whatever is left.
    always @*
    begin
        if (io_word == `PRDR_CFG_ADDR_PORT)
            next_target = `PRDR_IOT_CFGA;
        else if (io_word == `PRDR_CFG_DATA_PORT)
            next_target = `PRDR_IOT_CFGD;
        else if (io_addr <= `PRDR_IO_BOARD0_HI
                 || in_range(io_addr, `PRDR_IO_BOARD1_LO, `PRDR_IO_BOARD1_HI)
                 || in_range(io_addr, `PRDR_IO_BOARD2_LO, `PRDR_IO_BOARD2_HI))
            next_target = `PRDR_IOT_BOARD;
        else if (in_range(io_addr, `PRDR_IO_LPC0_LO, `PRDR_IO_LPC0_HI)
                 || in_range(io_addr, `PRDR_IO_LPC1_LO, `PRDR_IO_LPC1_HI)
                 || in_range(io_addr, `PRDR_IO_LPC2_LO, `PRDR_IO_LPC2_HI))
            next_target = `PRDR_IOT_LPC;
        else
            next_target = `PRDR_IOT_PCI;
    end

    // Read data for a config port access; other reads return zero.
    always @*
    begin
        next_rdata = 32'h0000_0000;
        if (cyc_io_in && !cyc_write_in)
        begin
            if (next_target == `PRDR_IOT_CFGA)
                next_rdata = config_address_out;
            else if (next_target == `PRDR_IOT_CFGD)
                next_rdata = cfg_rdata_in;
        end
    end

    // ------------------------------------------------------------
    // Registered results
    // ------------------------------------------------------------

    // One cycle after a valid strobe the valid flag pulses for one cycle; the decode result holds until the next cycle of its kind.
    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mem_region_valid_out <= 1'b0;
            mem_region_out <= `PRDR_MREG_CONV;
            io_valid_out <= 1'b0;
            io_target_out <= `PRDR_IOT_PCI;
            rdata_out <= 32'h0000_0000;
            config_address_out <= `PRDR_CFG_ADDR_RESET;
            cfg_data_strobe_out <= 1'b0;
            cfg_data_write_out <= 1'b0;
            cfg_wdata_out <= 32'h0000_0000;
            io_in_alloc_area_out <= 1'b0;
        end
        else
        begin
            mem_region_valid_out <= cyc_valid_in && !cyc_io_in;
            io_valid_out <= cyc_valid_in && cyc_io_in;
            cfg_data_strobe_out <= 1'b0;
            if (cyc_valid_in && !cyc_io_in)
                mem_region_out <= next_region;
            if (cyc_valid_in && cyc_io_in)
            begin
                io_target_out <= next_target;
                rdata_out <= next_rdata;
                // flag cycles inside the downward-allocated window
                io_in_alloc_area_out <= (next_target == `PRDR_IOT_PCI)
                    && (io_addr <= `PRDR_IO_ALLOC_TOP);
                if (cyc_write_in && next_target == `PRDR_IOT_CFGA)
                    config_address_out <= cyc_wdata_in;
                // data port access strobed to config space
                if (next_target == `PRDR_IOT_CFGD)
                begin
                    cfg_data_strobe_out <= 1'b1;
                    cfg_data_write_out <= cyc_write_in;
                    cfg_wdata_out <= cyc_wdata_in;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt routing
    // ------------------------------------------------------------

    // Router registers its outputs; IRQs lag their sources by one cycle.
    prdr_irq_route u_route
    (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .apic_mode_in(apic_mode_in),
        .pci_int_in(pci_int_in),
        .route_line_in(route_line_in),
        .serial_irq_in(serial_irq_in),
        .fixed_src_in(fixed_src_in),
        .root_port_in(root_port_in),
        .dev_irq_in(dev_irq_in),
        .steer_in(steer_in),
        .irq_out(irq_out)
    );

endmodule // prdr_top

`default_nettype wire

/* File: include/prdr_regs.vh */
// Constants for the resource decoder and interrupt router.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef PRDR_REGS_VH
`define PRDR_REGS_VH

// I/O register offsets (byte addresses).
`define PRDR_CFG_ADDR_PORT 16'h0cf8
`define PRDR_CFG_DATA_PORT 16'h0cfc
`define PRDR_CFG_ADDR_RESET 32'h0000_0000

// Fixed legacy memory regions (byte addresses, 20-bit boundaries).
`define PRDR_MEM_EBDA_LO 32'h0009_fc00
`define PRDR_MEM_VIDEO_LO 32'h000a_0000
`define PRDR_MEM_EXP_LO 32'h000c_0000
`define PRDR_MEM_RTBIOS_LO 32'h000e_0000
`define PRDR_MEM_EXT_LO 32'h0010_0000

// Memory region codes.
`define PRDR_MREG_CONV 3'h0
`define PRDR_MREG_EBDA 3'h1
`define PRDR_MREG_VIDEO 3'h2
`define PRDR_MREG_EXP 3'h3
`define PRDR_MREG_RTBIOS 3'h4
`define PRDR_MREG_EXT 3'h5
`define PRDR_MREG_HIGH 3'h6

// I/O target codes.
`define PRDR_IOT_BOARD 3'h0
`define PRDR_IOT_CFGA 3'h1
`define PRDR_IOT_CFGD 3'h2
`define PRDR_IOT_LPC 3'h3
`define PRDR_IOT_PCI 3'h4

// On-board and LPC I/O ranges.
`define PRDR_IO_BOARD0_HI 16'h00ff
`define PRDR_IO_BOARD1_LO 16'h0400
`define PRDR_IO_BOARD1_HI 16'h047f
`define PRDR_IO_BOARD2_LO 16'h0500
`define PRDR_IO_BOARD2_HI 16'h057f
`define PRDR_IO_LPC0_LO 16'h03f8
`define PRDR_IO_LPC0_HI 16'h03ff
`define PRDR_IO_LPC1_LO 16'h03e8
`define PRDR_IO_LPC1_HI 16'h03ef
`define PRDR_IO_LPC2_LO 16'h0a00
`define PRDR_IO_LPC2_HI 16'h0a0f
`define PRDR_IO_ALLOC_TOP 16'hfff0

// Reserved IRQ mask (0,1,2,8,9,13) and serial-capable IRQ mask (3-7,10-12).
`define PRDR_IRQ_RESERVED 16'h2307
`define PRDR_IRQ_SERIAL 16'h1cf8
`define PRDR_IRQ_PCI_ONLY 16'hc000
`define PRDR_IRQ_SCI 9

`endif

/* File: design/prdr_irq_route.v */
// Interrupt router: PIC and APIC steering of legacy and PCI sources.
// Assumes level-high, already synchronous interrupt inputs; steering codes from parent.
`timescale 1ns/100ps
`default_nettype none
`include "prdr_regs.vh"

module prdr_irq_route
(
    input wire mclk_in,
    input wire rst_n_in,
    input wire apic_mode_in,
    input wire [3:0] pci_int_in,
    input wire [7:0] route_line_in,
    input wire [15:0] serial_irq_in,
    input wire [6:0] fixed_src_in,
    input wire [5:0] root_port_in,
    input wire [7:0] dev_irq_in,
    input wire [15:0] steer_in,
    output reg [23:0] irq_out
);

    reg [23:0] next_irq;
    reg [15:0] pic_pci;
    integer i;

    // Combine every source except fixed_src_in[6] into the 24 IRQ inputs for the current mode.
    always @*
    begin
        next_irq = 24'h00_0000;
        pic_pci = 16'h0000;
        next_irq[0] = fixed_src_in[0];
        next_irq[1] = fixed_src_in[1];
        next_irq[2] = fixed_src_in[2];
        next_irq[8] = fixed_src_in[3];
        next_irq[`PRDR_IRQ_SCI] = fixed_src_in[4];
        next_irq[13] = fixed_src_in[5];
        if (!apic_mode_in)
        begin
            // steer each PCI line to any free IRQ
            for (i = 0; i < 4; i = i + 1)
                if (((`PRDR_IRQ_RESERVED >> steer_in[i*4 +: 4]) & 16'h0001) == 16'h0000)
                    pic_pci[steer_in[i*4 +: 4]] = pic_pci[steer_in[i*4 +: 4]] | pci_int_in[i];
            // serial on 3-7,10-12; PCI on those and 14-15
            next_irq[15:0] = next_irq[15:0] | (serial_irq_in & `PRDR_IRQ_SERIAL)
                | (pic_pci & (`PRDR_IRQ_SERIAL | `PRDR_IRQ_PCI_ONLY));
        end
        else
        begin
            // serial only on legacy IRQs in APIC mode
            next_irq[15:0] = next_irq[15:0] | (serial_irq_in & `PRDR_IRQ_SERIAL);
            next_irq[16] = route_line_in[0] | pci_int_in[1] | dev_irq_in[0]
                | root_port_in[0] | root_port_in[4] | dev_irq_in[1];
            next_irq[17] = route_line_in[1] | pci_int_in[2] | root_port_in[1] | root_port_in[5];
            next_irq[18] = route_line_in[2] | pci_int_in[3] | root_port_in[2] | dev_irq_in[2];
            next_irq[19] = route_line_in[3] | pci_int_in[0] | root_port_in[3]
                | dev_irq_in[3] | dev_irq_in[4];
            next_irq[20] = route_line_in[4] | dev_irq_in[5];
            next_irq[21] = route_line_in[5];
            next_irq[22] = route_line_in[6] | dev_irq_in[6];
            next_irq[23] = route_line_in[7] | dev_irq_in[7];
        end
    end

    // Register the IRQ vector so outputs are glitch free.
    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            irq_out <= 24'h00_0000;
        else
            irq_out <= next_irq;
    end

endmodule // prdr_irq_route

`default_nettype wire

/* File: dv/prdr_top_asserts.sv */
// Port checker for prdr_top, bound in after the module.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module prdr_top_asserts
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic cyc_valid_in,
    input wire logic cyc_io_in,
    input wire logic [31:0] cyc_addr_in,
    input wire logic mem_region_valid_out,
    input wire logic [2:0] mem_region_out,
    input wire logic io_valid_out,
    input wire logic [2:0] io_target_out,
    input wire logic cfg_data_strobe_out,
    input wire logic apic_mode_in,
    input wire logic [3:0] pci_int_in,
    input wire logic [23:0] irq_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);
    logic io_req;
    logic mem_req;
    // Split host cycles by kind; each kind must answer on its own path only.
    assign io_req = cyc_valid_in & cyc_io_in;
    assign mem_req = cyc_valid_in & ~cyc_io_in;
    chk_io_answer: assert property (io_req |=> io_valid_out && !mem_region_valid_out)
        else $error("io cycle not answered");
    chk_mem_answer: assert property (mem_req |=> mem_region_valid_out && !io_valid_out)
        else $error("memory cycle not answered");
    chk_cfg_addr: assert property (io_req && cyc_addr_in[15:2] == 14'h033e |=> io_target_out == 3'h1)
        else $error("config address port missed");
    chk_cfg_data: assert property (io_req && cyc_addr_in[15:2] == 14'h033f ##1 1'b1 |-> io_target_out == 3'h2 && cfg_data_strobe_out)
        else $error("config data port missed");
    chk_board_claim: assert property (io_req && cyc_addr_in[15:8] == 8'h00 |=> io_target_out == 3'h0)
        else $error("board range not claimed");
    chk_lpc_range: assert property (io_valid_out && io_target_out == 3'h3 |-> $past(cyc_addr_in[15:3]) inside {13'h007f, 13'h007d} || $past(cyc_addr_in[15:4]) == 12'h0a0)
        else $error("lpc target outside its ranges");
    chk_video_region: assert property (mem_req && cyc_addr_in[31:17] == 15'h0005 |=> mem_region_out == 3'h2)
        else $error("video region missed");
    chk_apic_intb: assert property (apic_mode_in && pci_int_in[1] |=> irq_out[16])
        else $error("apic line 16 missing");
    cov_cfg_data: cover property (io_req && cyc_addr_in[15:2] == 14'h033f);
    cov_lpc: cover property (io_valid_out && io_target_out == 3'h3);
    cov_apic: cover property (apic_mode_in && pci_int_in[1]);
endmodule // prdr_top_asserts
bind prdr_top prdr_top_asserts u_prdr_top_asserts
(
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .cyc_valid_in(cyc_valid_in),
    .cyc_io_in(cyc_io_in), .cyc_addr_in(cyc_addr_in), .io_valid_out(io_valid_out),
    .mem_region_valid_out(mem_region_valid_out), .mem_region_out(mem_region_out),
    .io_target_out(io_target_out), .cfg_data_strobe_out(cfg_data_strobe_out),
    .apic_mode_in(apic_mode_in), .pci_int_in(pci_int_in), .irq_out(irq_out)
);
`default_nettype wire

/* File: dv/prdr_host.sv */
// Host processor model: one memory or I/O cycle per call.
// Assumes the decoder takes a cycle at the edge after it is driven.
`timescale 1ns/100ps
`default_nettype none
module prdr_host
(
    input wire logic mclk_in,
    output var logic cyc_valid_out,
    output var logic cyc_io_out,
    output var logic cyc_write_out,
    output var logic [31:0] cyc_addr_out,
    output var logic [31:0] cyc_wdata_out
);
    // Idle bus from time zero.
    initial
    begin
        cyc_valid_out = 1'b0;
        cyc_io_out = 1'b0;
        cyc_write_out = 1'b0;
        cyc_addr_out = 32'h0000_0000;
        cyc_wdata_out = 32'h0000_0000;
    end
    // Released address and write data are inverted so a stale address can never pass as a match.
    task automatic issue(input logic i, input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        cyc_valid_out <= 1'b1;
        cyc_io_out <= i;
        cyc_write_out <= w;
        cyc_addr_out <= a;
        cyc_wdata_out <= d;
        @(posedge mclk_in);
        cyc_valid_out <= 1'b0;
        cyc_addr_out <= ~a;
        cyc_wdata_out <= ~d;
        #1;
    endtask
endmodule // prdr_host
`default_nettype wire

/* File: dv/prdr_top_tb.sv */
// Self-checking bench for prdr_top: memory map, I/O steering, IRQ routing.
// Assumes prdr_host drives host cycles and the checker is bound in.
`timescale 1ns/100ps
`default_nettype none
module prdr_top_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic apic = 1'b0;
    logic [3:0] pci = 4'h0;
    logic [7:0] rte = 8'h00;
    logic [7:0] dev = 8'h00;
    logic [5:0] rp = 6'h00;
    logic [15:0] ser = 16'h0000;
    logic [15:0] steer = 16'h0000;
    logic [6:0] fix = 7'h00;
    wire logic vld, io, wr, mvld, iovld, dstb, dwr, alloc;
    wire logic [2:0] region, tgt;
    wire logic [31:0] addr, wdat, rdat, cadr, cwd;
    wire logic [23:0] irq;
    integer failures = 0;
    integer checks_done = 0;
    logic [18:0] io_tab [0:19] = '{19'h0_0000, 19'h0_00ff, 19'h4_0100, 19'h3_03f8, 19'h3_03ff,
        19'h4_03f7, 19'h3_03e8, 19'h3_03ef, 19'h4_03f0, 19'h0_0400, 19'h0_047f, 19'h4_0480,
        19'h0_0500, 19'h0_057f, 19'h4_0580, 19'h3_0a00, 19'h3_0a0f, 19'h4_0a10, 19'h4_fff0,
        19'h4_ffff};
    logic [34:0] mem_tab [0:13] = '{35'h0_0000_0000, 35'h0_0009_fbff, 35'h1_0009_fc00,
        35'h1_0009_ffff, 35'h2_000a_0000, 35'h2_000b_ffff, 35'h3_000c_0000, 35'h3_000d_ffff,
        35'h4_000e_0000, 35'h4_000f_ffff, 35'h5_0010_0000, 35'h5_3eff_ffff, 35'h6_3f00_0000,
        35'h6_4000_0000};
    logic [4:0] rp_irq [0:5] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h10, 5'h11};
    logic [4:0] dv_irq [0:7] = '{5'h10, 5'h10, 5'h12, 5'h13, 5'h13, 5'h14, 5'h16, 5'h17};
    // The 100 ns period gives the 10 MHz system clock.
    always #50 clk = ~clk;
    prdr_host u_prdr_host
    (
        .mclk_in(clk), .cyc_valid_out(vld), .cyc_io_out(io), .cyc_write_out(wr),
        .cyc_addr_out(addr), .cyc_wdata_out(wdat)
    );
    prdr_top u_prdr_top
    (
        .mclk_in(clk), .rst_n_in(rst_n), .cyc_valid_in(vld), .cyc_io_in(io),
        .cyc_write_in(wr), .cyc_addr_in(addr), .cyc_wdata_in(wdat),
        .top_of_dram_in(32'h4000_0000), .high_window_in(32'h3f00_0000),
        .cfg_rdata_in(32'h5a5a_0f0f), .mem_region_valid_out(mvld), .mem_region_out(region),
        .io_valid_out(iovld), .io_target_out(tgt), .rdata_out(rdat),
        .config_address_out(cadr), .cfg_data_strobe_out(dstb), .cfg_data_write_out(dwr),
        .cfg_wdata_out(cwd), .io_in_alloc_area_out(alloc), .apic_mode_in(apic),
        .pci_int_in(pci), .route_line_in(rte), .serial_irq_in(ser), .fixed_src_in(fix),
        .root_port_in(rp), .dev_irq_in(dev), .steer_in(steer), .irq_out(irq)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("checks=%0d mismatches=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Interrupt outputs follow their sources one cycle later.
    task automatic irq_chk(input logic [3:0] p, input logic [7:0] r, input logic [5:0] q,
        input logic [7:0] d, input logic [23:0] exp);
        @(posedge clk);
        pci <= p;
        rte <= r;
        rp <= q;
        dev <= d;
        @(posedge clk);
        #1;
        check(irq, exp);
    endtask
    task t_cfg;
        u_prdr_host.issue(1'b1, 1'b1, 32'h0000_0cf8, 32'h8000_f804);
        check(tgt, 3'h1);
        check(cadr, 32'h8000_f804);
        u_prdr_host.issue(1'b1, 1'b0, 32'h0000_0cfb, 32'h0000_0000);
        check(rdat, 32'h8000_f804);
        u_prdr_host.issue(1'b1, 1'b1, 32'h0000_0cfe, 32'h1357_9bdf);
        check({dstb, dwr, tgt}, 5'h1a);
        check(cwd, 32'h1357_9bdf);
        u_prdr_host.issue(1'b1, 1'b0, 32'h0000_0cfc, 32'h0000_0000);
        check(rdat, 32'h5a5a_0f0f);
        check({dstb, dwr, tgt}, 5'h12);
        $display("config port test done");
    endtask
    task t_io;
        for (int i = 0; i < 20; i++)
        begin
            u_prdr_host.issue(1'b1, 1'b0, {16'h0000, io_tab[i][15:0]}, 32'h0000_0000);
            check(iovld, 1'b1);
            check(tgt, io_tab[i][18:16]);
            if (io_tab[i][18:16] == 3'h4)
                check(alloc, io_tab[i][15:0] <= 16'hfff0);
        end
        $display("io steering test done");
    endtask
    task t_mem;
        for (int i = 0; i < 14; i++)
        begin
            u_prdr_host.issue(1'b0, 1'b0, mem_tab[i][31:0], 32'h0000_0000);
            check({mvld, region}, {1'b1, mem_tab[i][34:32]});
        end
        $display("memory map test done");
    endtask
    // Line D is steered to the SCI line, which must be dropped.
    task t_pic;
        fix <= 7'h3f;
        irq_chk(4'h0, 8'h00, 6'h00, 8'h00, 24'h00_2307);
        fix <= 7'h00;
        steer <= 16'h9fe5;
        irq_chk(4'hf, 8'h00, 6'h00, 8'h00, 24'h00_c020);
        ser <= 16'hffff;
        irq_chk(4'h0, 8'h00, 6'h00, 8'h00, 24'h00_1cf8);
        $display("pic routing test done");
    endtask
    task t_apic;
        apic <= 1'b1;
        fix <= 7'h3f;
        irq_chk(4'hf, 8'h00, 6'h00, 8'h00, 24'h0f_3fff);
        ser <= 16'h0000;
        fix <= 7'h00;
        for (int i = 0; i < 8; i++)
        begin
            irq_chk(4'h0, 8'h01 << i, 6'h00, 8'h00, 24'h01_0000 << i);
            irq_chk(4'h0, 8'h00, 6'h00, 8'h01 << i, 24'h00_0001 << dv_irq[i]);
            if (i < 6)
                irq_chk(4'h0, 8'h00, 6'h01 << i, 8'h00, 24'h00_0001 << rp_irq[i]);
        end
        $display("apic routing test done");
    endtask
    // Outputs are checked at their reset values before the release.
    initial
    begin
        repeat (12) @(posedge clk);
        check(tgt, 3'h4);
        check(cadr, 32'h0000_0000);
        check(irq, 24'h00_0000);
        rst_n <= 1'b1;
        t_cfg;
        t_io;
        t_mem;
        t_pic;
        t_apic;
        print_verdict;
    end
    // A hang counts as a mismatch and ends the run.
    initial
    begin
        #200000;
        failures = failures + 1;
        print_verdict;
    end
endmodule // prdr_top_tb
`default_nettype wire
